// file: logic/efsb_pkg.sv
package efsb_pkg;

  localparam int REG_W = 8;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;

  // register offsets
  localparam logic [7:0] ADDR_PROG_ROUTE = 8'h0f;
  localparam logic [7:0] ADDR_LEARN_ROUTE = 8'h11;
  localparam logic [7:0] ADDR_MOTION_STATUS = 8'h12;
  localparam logic [7:0] ADDR_PROG_STATUS = 8'h13;
  localparam logic [7:0] ADDR_LEARN_STATUS = 8'h15;
  localparam logic [7:0] ADDR_PAGE_ACCESS = 8'h17;
  localparam logic [7:0] ADDR_BATCH_A = 8'h44;
  localparam logic [7:0] ADDR_BATCH_B = 8'h45;
  localparam logic [7:0] ADDR_PROG_ENABLE = 8'h46;

  // implemented bits of each register, reserved bits read zero
  localparam logic [REG_W-1:0] MASK_PROG_ROUTE = 8'hff;
  localparam logic [REG_W-1:0] MASK_LEARN_ROUTE = 8'h0f;
  localparam logic [REG_W-1:0] MASK_MOTION_STATUS = 8'hb8;
  localparam logic [REG_W-1:0] MASK_PROG_STATUS = 8'hff;
  localparam logic [REG_W-1:0] MASK_LEARN_STATUS = 8'h0f;
  localparam logic [REG_W-1:0] MASK_PAGE_ACCESS = 8'he0;
  localparam logic [REG_W-1:0] MASK_BATCH_A = 8'hf2;
  localparam logic [REG_W-1:0] MASK_BATCH_B = 8'h02;
  localparam logic [REG_W-1:0] MASK_PROG_ENABLE = 8'hff;

  // field positions
  localparam int BIT_LONG_COUNTER = 7;
  localparam int BIT_SIG_MOTION = 5;
  localparam int BIT_TILT = 4;
  localparam int BIT_STEP_DETECT = 3;
  localparam int BIT_LATCHED_SELECT = 7;
  localparam int BIT_PAGE_WRITE = 6;
  localparam int BIT_PAGE_READ = 5;
  localparam int BIT_LEARN_RESULT = 7;
  localparam int BIT_STEP_COUNT = 6;
  localparam int BIT_GYRO_BIAS = 5;
  localparam int BIT_GRAVITY = 4;
  localparam int BIT_QUATERNION = 1;
  localparam int BIT_LEARN_FEATURE = 1;

  localparam int PAGE_SEL_W = 4;

endpackage

// file: logic/efsb_flag_if.sv
`timescale 1ns/1ps
interface efsb_flag_if;
  import efsb_pkg::*;
  logic [REG_W-1:0] event_in;
  logic [REG_W-1:0] keep_mask;
  logic latched;
  logic read_ack;
  logic [REG_W-1:0] flags;

  modport owner (
    output event_in,
    output keep_mask,
    output latched,
    output read_ack,
    input flags
  );
  modport keeper (
    input event_in,
    input keep_mask,
    input latched,
    input read_ack,
    output flags
  );
endinterface

// file: logic/efsb_status_flags.sv
`timescale 1ns/1ps
module efsb_status_flags (
  input wire logic core_clk,
  input wire logic reset_n,
  efsb_flag_if.keeper port_if
);
  import efsb_pkg::*;

  logic [REG_W-1:0] next_flags;

  // latched: hold until read, read clears unkept bits, a new event wins over the clear
  always_comb begin
    if (port_if.latched) begin
      next_flags = port_if.flags | port_if.event_in;
      if (port_if.read_ack) begin
        next_flags = (port_if.flags & port_if.keep_mask) | port_if.event_in;
      end
    end else begin
      next_flags = port_if.event_in;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_if.flags <= REG_RESET;
    end else begin
      port_if.flags <= next_flags;
    end
  end

  a_read_clears_unkept: assert property (@(posedge core_clk) disable iff (!reset_n)
    (port_if.latched && port_if.read_ack && port_if.event_in == '0) |=>
      (port_if.flags & ~$past(port_if.keep_mask)) == '0 && (port_if.flags == ($past(port_if.flags) & $past(port_if.keep_mask))))
    else $error("latched read did not clear unkept flags");

  a_unlatched_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    !port_if.latched |=> port_if.flags == $past(port_if.event_in))
    else $error("unlatched flags do not follow events");

  a_event_sets_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    port_if.latched |=> (port_if.flags & $past(port_if.event_in)) == $past(port_if.event_in))
    else $error("event lost in latched mode");

endmodule

// file: logic/efsb_pin2_route.sv
`timescale 1ns/1ps
module efsb_pin2_route (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [efsb_pkg::REG_W-1:0] prog_flags,
  input wire logic [efsb_pkg::REG_W-1:0] prog_route,
  input wire logic [efsb_pkg::REG_W-1:0] learn_flags,
  input wire logic [efsb_pkg::REG_W-1:0] learn_route,
  input wire logic route_enable,
  output logic pin2
);
  import efsb_pkg::*;

  logic next_pin2;

  always_comb begin
    next_pin2 = |(learn_flags & learn_route & MASK_LEARN_ROUTE);
    if (route_enable) begin
      next_pin2 = next_pin2 | (|(prog_flags & prog_route));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin2 <= 1'b0;
    end else begin
      pin2 <= next_pin2;
    end
  end

endmodule

// file: logic/efsb_bank.sv
// What this block does
// - second interrupt pin is the OR of every routed event source.
// - program routing to pin 2 acts only while the embedded route enable is 1.
// - program routing register: bit n-1 routes program n to pin 2; resets 0.
// - learning routing register low four bits route outputs 1..4; reset 0.
// - motion status flags: long counter bit 7, motion 5, tilt 4, step 3.
// - program status bit n-1 reads 1 when program n raised its event while its program enable bit is 1.
// - learning status bits 3..0 for outputs 4..1, upper bits read zero.
// - page access bit 7 selects latched requests; resets 0.
// - page access bit 6 enables writes to selected page; resets 0.
// - page access bit 5 enables reads from selected page; resets 0.
// - targeted page is the four-bit page select field.
// - batching A bit 7 batches learning results; resets 0.
// - batching A bit 6 batches step counter values; resets 0.
// - batching A bits 5, 4, 1 batch gyro bias, gravity, quaternion.
// - batching B bit 1 batches learning filters and features; resets 0.
// - program enable bit n-1 enables program n; all cleared at reset.
// - latched read clears status bits whose keep mask bit is 0.
`timescale 1ns/1ps
module efsb_bank (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [efsb_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [efsb_pkg::REG_W-1:0] reg_rdata,
  input wire logic long_counter_event,
  input wire logic sig_motion_event,
  input wire logic tilt_event,
  input wire logic step_detect_event,
  input wire logic [efsb_pkg::REG_W-1:0] program_event,
  input wire logic [3:0] learning_event,
  input wire logic pin2_embedded_route_enable,
  input wire logic [efsb_pkg::REG_W-1:0] ack_keep_mask,
  input wire logic [efsb_pkg::PAGE_SEL_W-1:0] page_select,
  output logic second_interrupt_pin,
  output logic latched_request_select,
  output logic page_write_enable,
  output logic page_read_enable,
  output logic [efsb_pkg::PAGE_SEL_W-1:0] page_target,
  output logic learning_result_batch_en,
  output logic step_count_batch_en,
  output logic gyro_bias_batch_en,
  output logic gravity_batch_en,
  output logic quaternion_batch_en,
  output logic learning_feature_batch_en,
  output logic [efsb_pkg::REG_W-1:0] program_enable
);
  import efsb_pkg::*;

  logic [REG_W-1:0] program_event_route_pin2;
  logic [REG_W-1:0] learning_event_route_pin2;
  logic [REG_W-1:0] page_access_control;
  logic [REG_W-1:0] result_batching_enable_a;
  logic [REG_W-1:0] result_batching_enable_b;
  logic [REG_W-1:0] next_rdata;

  efsb_flag_if motion_if ();
  efsb_flag_if prog_if ();
  efsb_flag_if learn_if ();

  function automatic logic hit_write(input logic [7:0] addr, input logic wr, input logic [7:0] target);
    hit_write = wr && (addr == target);
  endfunction

  function automatic logic [REG_W-1:0] keep_defined(input logic [REG_W-1:0] data, input logic [REG_W-1:0] mask);
    keep_defined = data & mask;
  endfunction

  // routing registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_event_route_pin2 <= REG_RESET;
      learning_event_route_pin2 <= REG_RESET;
    end else begin
      if (hit_write(reg_addr, reg_wr, ADDR_PROG_ROUTE)) begin
        program_event_route_pin2 <= keep_defined(reg_wdata, MASK_PROG_ROUTE);
      end
      if (hit_write(reg_addr, reg_wr, ADDR_LEARN_ROUTE)) begin
        learning_event_route_pin2 <= keep_defined(reg_wdata, MASK_LEARN_ROUTE);
      end
    end
  end

  // page access control
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_access_control <= REG_RESET;
    end else if (hit_write(reg_addr, reg_wr, ADDR_PAGE_ACCESS)) begin
      page_access_control <= keep_defined(reg_wdata, MASK_PAGE_ACCESS);
    end
  end

  // batching and program enables
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_batching_enable_a <= REG_RESET;
      result_batching_enable_b <= REG_RESET;
      program_enable <= REG_RESET;
    end else begin
      if (hit_write(reg_addr, reg_wr, ADDR_BATCH_A)) begin
        result_batching_enable_a <= keep_defined(reg_wdata, MASK_BATCH_A);
      end
      if (hit_write(reg_addr, reg_wr, ADDR_BATCH_B)) begin
        result_batching_enable_b <= keep_defined(reg_wdata, MASK_BATCH_B);
      end
      if (hit_write(reg_addr, reg_wr, ADDR_PROG_ENABLE)) begin
        program_enable <= keep_defined(reg_wdata, MASK_PROG_ENABLE);
      end
    end
  end

  // control outputs, one cycle after the backing register, page_target one cycle after page_select
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latched_request_select <= 1'b0;
      page_write_enable <= 1'b0;
      page_read_enable <= 1'b0;
      page_target <= '0;
      learning_result_batch_en <= 1'b0;
      step_count_batch_en <= 1'b0;
      gyro_bias_batch_en <= 1'b0;
      gravity_batch_en <= 1'b0;
      quaternion_batch_en <= 1'b0;
      learning_feature_batch_en <= 1'b0;
    end else begin
      latched_request_select <= page_access_control[BIT_LATCHED_SELECT];
      page_write_enable <= page_access_control[BIT_PAGE_WRITE];
      page_read_enable <= page_access_control[BIT_PAGE_READ];
      page_target <= page_select;
      learning_result_batch_en <= result_batching_enable_a[BIT_LEARN_RESULT];
      step_count_batch_en <= result_batching_enable_a[BIT_STEP_COUNT];
      gyro_bias_batch_en <= result_batching_enable_a[BIT_GYRO_BIAS];
      gravity_batch_en <= result_batching_enable_a[BIT_GRAVITY];
      quaternion_batch_en <= result_batching_enable_a[BIT_QUATERNION];
      learning_feature_batch_en <= result_batching_enable_b[BIT_LEARN_FEATURE];
    end
  end

  // status flag sources
  always_comb begin
    motion_if.event_in = '0;
    motion_if.event_in[BIT_LONG_COUNTER] = long_counter_event;
    motion_if.event_in[BIT_SIG_MOTION] = sig_motion_event;
    motion_if.event_in[BIT_TILT] = tilt_event;
    motion_if.event_in[BIT_STEP_DETECT] = step_detect_event;
  end

  assign prog_if.event_in = program_event & program_enable;
  assign learn_if.event_in = {4'h0, learning_event};

  assign motion_if.latched = page_access_control[BIT_LATCHED_SELECT];
  assign prog_if.latched = page_access_control[BIT_LATCHED_SELECT];
  assign learn_if.latched = page_access_control[BIT_LATCHED_SELECT];
  assign motion_if.keep_mask = ack_keep_mask;
  assign prog_if.keep_mask = ack_keep_mask;
  assign learn_if.keep_mask = ack_keep_mask;
  assign motion_if.read_ack = hit_write(reg_addr, reg_rd, ADDR_MOTION_STATUS);
  assign prog_if.read_ack = hit_write(reg_addr, reg_rd, ADDR_PROG_STATUS);
  assign learn_if.read_ack = hit_write(reg_addr, reg_rd, ADDR_LEARN_STATUS);

  efsb_status_flags u_motion_flags (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .port_if(motion_if.keeper)
  );

  efsb_status_flags u_prog_flags (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .port_if(prog_if.keeper)
  );

  efsb_status_flags u_learn_flags (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .port_if(learn_if.keeper)
  );

  efsb_pin2_route u_pin2_route (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .prog_flags(prog_if.flags),
    .prog_route(program_event_route_pin2),
    .learn_flags(learn_if.flags),
    .learn_route(learning_event_route_pin2),
    .route_enable(pin2_embedded_route_enable),
    .pin2(second_interrupt_pin)
  );

  // read mux, unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      ADDR_PROG_ROUTE: next_rdata = program_event_route_pin2;
      ADDR_LEARN_ROUTE: next_rdata = learning_event_route_pin2;
      ADDR_MOTION_STATUS: next_rdata = motion_if.flags & MASK_MOTION_STATUS;
      ADDR_PROG_STATUS: next_rdata = prog_if.flags & MASK_PROG_STATUS;
      ADDR_LEARN_STATUS: next_rdata = learn_if.flags & MASK_LEARN_STATUS;
      ADDR_PAGE_ACCESS: next_rdata = page_access_control;
      ADDR_BATCH_A: next_rdata = result_batching_enable_a;
      ADDR_BATCH_B: next_rdata = result_batching_enable_b;
      ADDR_PROG_ENABLE: next_rdata = program_enable;
      default: next_rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= REG_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  a_pin2_routed_program: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pin2_embedded_route_enable && |(prog_if.flags & program_event_route_pin2)) |=> second_interrupt_pin)
    else $error("routed program event missing on pin 2");

  a_pin2_gated_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!pin2_embedded_route_enable && !(|(learn_if.flags & learning_event_route_pin2))) |=> !second_interrupt_pin)
    else $error("pin 2 high with routing disabled");

  a_learn_routed: assert property (@(posedge core_clk) disable iff (!reset_n)
    |(learn_if.flags & learning_event_route_pin2) |=> second_interrupt_pin)
    else $error("routed learning event missing on pin 2");

  a_prog_route_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_PROG_ROUTE) |=> program_event_route_pin2 == $past(reg_wdata))
    else $error("program routing write lost");

  a_learn_route_upper: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_LEARN_ROUTE) |=>
      learning_event_route_pin2 == ($past(reg_wdata) & 8'h0f))
    else $error("learning routing write wrong");

  a_motion_status_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_MOTION_STATUS) |=> (reg_rdata & 8'h47) == 8'h00)
    else $error("motion status reserved bit set");

  a_learn_status_upper: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_LEARN_STATUS) |=> reg_rdata[7:4] == 4'h0)
    else $error("learning status upper bits nonzero");

  a_page_access_out: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_PAGE_ACCESS) |=> ##1
      (latched_request_select == $past(reg_wdata[7], 2) && page_write_enable == $past(reg_wdata[6], 2)
       && page_read_enable == $past(reg_wdata[5], 2)))
    else $error("page access outputs wrong");

  a_page_target: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> page_target == $past(page_select))
    else $error("page target not tracking select");

  a_batch_a_out: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_BATCH_A) |=> ##1
      ({learning_result_batch_en, step_count_batch_en, gyro_bias_batch_en, gravity_batch_en,
        quaternion_batch_en} == {$past(reg_wdata[7:4], 2), $past(reg_wdata[1], 2)}))
    else $error("batching A outputs wrong");

  a_batch_b_out: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_BATCH_B) |=> ##1 learning_feature_batch_en == $past(reg_wdata[1], 2))
    else $error("batching B output wrong");

  a_prog_enable_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!page_access_control[BIT_LATCHED_SELECT] && program_enable == 8'h00) |=> prog_if.flags == 8'h00)
    else $error("disabled program raised a flag");

  a_prog_enable_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_PROG_ENABLE) |=> program_enable == $past(reg_wdata))
    else $error("program enable write lost");

  a_batch_b_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_BATCH_B) |=> result_batching_enable_b == ($past(reg_wdata) & 8'h02))
    else $error("batching B write wrong");

  a_page_reserved_drop: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_PAGE_ACCESS) |=> page_access_control[4:0] == 5'h00)
    else $error("page access reserved bit kept");

  a_batch_a_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_wr && reg_addr == ADDR_BATCH_A) |=> (result_batching_enable_a & 8'h0d) == 8'h00)
    else $error("batching A reserved bit kept");

  a_prog_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_PROG_STATUS) |=> reg_rdata == $past(prog_if.flags))
    else $error("program status read wrong");

  a_motion_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_MOTION_STATUS) |=> reg_rdata == ($past(motion_if.flags) & 8'hb8))
    else $error("motion status read wrong");

  a_learn_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == ADDR_LEARN_STATUS) |=> reg_rdata == ($past(learn_if.flags) & 8'h0f))
    else $error("learning status read wrong");

  a_learn_flag_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
    !page_access_control[BIT_LATCHED_SELECT] |=> learn_if.flags == {4'h0, $past(learning_event)})
    else $error("unlatched learning flags do not follow events");

  a_pin2_idle_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!(|(prog_if.flags & program_event_route_pin2)) && !(|(learn_if.flags & learning_event_route_pin2)))
      |=> !second_interrupt_pin)
    else $error("pin 2 high with no routed event");

endmodule

// file: tb/efsb_host_model.sv
`timescale 1ns/1ps
module efsb_host_model (
  input wire logic core_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [efsb_pkg::REG_W-1:0] reg_wdata,
  output logic reg_rd,
  input wire logic [efsb_pkg::REG_W-1:0] reg_rdata
);
  import efsb_pkg::*;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_wdata = 8'h00;
    reg_rd = 1'h0;
  end

  // implemented bits per writable offset, everything else is sent as zero; other offsets send all bits
  function automatic logic [7:0] keep_bits(input logic [7:0] a);
    case (a)
      ADDR_PROG_ROUTE: keep_bits = MASK_PROG_ROUTE;
      ADDR_LEARN_ROUTE: keep_bits = MASK_LEARN_ROUTE;
      ADDR_PAGE_ACCESS: keep_bits = MASK_PAGE_ACCESS;
      ADDR_BATCH_A: keep_bits = MASK_BATCH_A;
      ADDR_BATCH_B: keep_bits = MASK_BATCH_B;
      ADDR_PROG_ENABLE: keep_bits = MASK_PROG_ENABLE;
      default: keep_bits = 8'hff;
    endcase
  endfunction

  // one-cycle write strobe, released lines show inverted values
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d & keep_bits(a);
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
    reg_wdata = ~reg_wdata;
    reg_addr = ~reg_addr;
  endtask

  // read data is taken the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    d = reg_rdata;
    reg_addr = ~reg_addr;
  endtask
endmodule

// file: tb/tb_efsb_bank.sv
`timescale 1ns/1ps
module tb_efsb_bank;
  import efsb_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, program_event, ack_keep_mask, program_enable;
  logic long_counter_event, sig_motion_event, tilt_event, step_detect_event, pin2_embedded_route_enable;
  logic [3:0] learning_event, page_select, page_target;
  logic second_interrupt_pin, latched_request_select, page_write_enable, page_read_enable;
  logic learning_result_batch_en, step_count_batch_en, gyro_bias_batch_en, gravity_batch_en;
  logic quaternion_batch_en, learning_feature_batch_en;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  efsb_bank DUT (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .long_counter_event, .sig_motion_event, .tilt_event, .step_detect_event, .program_event,
    .learning_event, .pin2_embedded_route_enable, .ack_keep_mask, .page_select, .second_interrupt_pin,
    .latched_request_select, .page_write_enable, .page_read_enable, .page_target, .learning_result_batch_en,
    .step_count_batch_en, .gyro_bias_batch_en, .gravity_batch_en, .quaternion_batch_en,
    .learning_feature_batch_en, .program_enable);
  efsb_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    chk(d, exp);
  endtask

  task automatic pin_chk(input logic exp);
    repeat (3) @(negedge core_clk);
    chk({7'h00, second_interrupt_pin}, {7'h00, exp});
  endtask

  task automatic give_verdict;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic t_reset_values;
    rd_chk(ADDR_PROG_ROUTE, 8'h00);
    rd_chk(ADDR_LEARN_ROUTE, 8'h00);
    rd_chk(ADDR_PAGE_ACCESS, 8'h00);
    rd_chk(ADDR_BATCH_A, 8'h00);
    rd_chk(ADDR_BATCH_B, 8'h00);
    rd_chk(ADDR_PROG_ENABLE, 8'h00);
    rd_chk(8'h20, 8'h00);
    chk({latched_request_select, page_write_enable, page_read_enable, 5'h00}, 8'h00);
    chk({learning_result_batch_en, step_count_batch_en, gyro_bias_batch_en, gravity_batch_en,
      quaternion_batch_en, 2'h0, learning_feature_batch_en}, 8'h00);
    program_event = 8'hff;
    host.write_reg(ADDR_PROG_STATUS, 8'hff);
    rd_chk(ADDR_PROG_STATUS, 8'h00);
    program_event = 8'h00;
  endtask

  task automatic t_controls;
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      e = 8'h01 << b;
      page_select = 4'(b + 9);
      host.write_reg(ADDR_PAGE_ACCESS, e);
      host.write_reg(ADDR_BATCH_A, e);
      host.write_reg(ADDR_BATCH_B, e);
      host.write_reg(ADDR_PROG_ENABLE, e);
      host.write_reg(ADDR_PROG_ROUTE, e);
      host.write_reg(ADDR_LEARN_ROUTE, e);
      @(negedge core_clk);
      chk({latched_request_select, page_write_enable, page_read_enable, 5'h00}, e & 8'he0);
      chk({learning_result_batch_en, step_count_batch_en, gyro_bias_batch_en, gravity_batch_en,
        2'h0, quaternion_batch_en, 1'h0}, e & 8'hf2);
      chk({6'h00, learning_feature_batch_en, 1'h0}, e & 8'h02);
      chk(program_enable, e);
      chk({4'h0, page_target}, {4'h0, page_select});
      rd_chk(ADDR_PAGE_ACCESS, e & 8'he0);
      rd_chk(ADDR_PROG_ROUTE, e);
      rd_chk(ADDR_LEARN_ROUTE, e & 8'h0f);
    end
    host.write_reg(ADDR_PAGE_ACCESS, 8'h00);
    host.write_reg(ADDR_LEARN_ROUTE, 8'h00);
  endtask

  task automatic t_unlatched;
    host.write_reg(ADDR_PROG_ENABLE, 8'h0f);
    @(negedge core_clk);
    program_event = 8'hff;
    learning_event = 4'h5;
    long_counter_event = 1'h1;
    tilt_event = 1'h1;
    rd_chk(ADDR_PROG_STATUS, 8'h0f);
    rd_chk(ADDR_LEARN_STATUS, 8'h05);
    rd_chk(ADDR_MOTION_STATUS, 8'h90);
    program_event = 8'h00;
    learning_event = 4'ha;
    long_counter_event = 1'h0;
    tilt_event = 1'h0;
    sig_motion_event = 1'h1;
    step_detect_event = 1'h1;
    rd_chk(ADDR_PROG_STATUS, 8'h00);
    rd_chk(ADDR_LEARN_STATUS, 8'h0a);
    rd_chk(ADDR_MOTION_STATUS, 8'h28);
    learning_event = 4'h0;
    sig_motion_event = 1'h0;
    step_detect_event = 1'h0;
    host.write_reg(ADDR_PROG_ENABLE, 8'hff);
    program_event = 8'h81;
    rd_chk(ADDR_PROG_STATUS, 8'h81);
    program_event = 8'h00;
  endtask

  task automatic t_latched;
    host.write_reg(ADDR_PAGE_ACCESS, 8'h80);
    ack_keep_mask = 8'h0c;
    @(negedge core_clk);
    program_event = 8'h3c;
    step_detect_event = 1'h1;
    learning_event = 4'h2;
    @(negedge core_clk);
    program_event = 8'h00;
    step_detect_event = 1'h0;
    learning_event = 4'h0;
    repeat (3) @(negedge core_clk);
    rd_chk(ADDR_PROG_STATUS, 8'h3c);
    rd_chk(ADDR_PROG_STATUS, 8'h0c);
    rd_chk(ADDR_MOTION_STATUS, 8'h08);
    rd_chk(ADDR_MOTION_STATUS, 8'h08);
    rd_chk(ADDR_LEARN_STATUS, 8'h02);
    rd_chk(ADDR_LEARN_STATUS, 8'h00);
    ack_keep_mask = 8'h00;
    rd_chk(ADDR_PROG_STATUS, 8'h0c);
    rd_chk(ADDR_PROG_STATUS, 8'h00);
    rd_chk(ADDR_MOTION_STATUS, 8'h08);
    rd_chk(ADDR_MOTION_STATUS, 8'h00);
    host.write_reg(ADDR_PAGE_ACCESS, 8'h00);
  endtask

  task automatic t_pin2;
    host.write_reg(ADDR_PROG_ROUTE, 8'h02);
    host.write_reg(ADDR_LEARN_ROUTE, 8'h08);
    program_event = 8'h02;
    pin_chk(1'h0);
    pin2_embedded_route_enable = 1'h1;
    pin_chk(1'h1);
    program_event = 8'hfd;
    pin_chk(1'h0);
    program_event = 8'h00;
    pin2_embedded_route_enable = 1'h0;
    learning_event = 4'h7;
    pin_chk(1'h0);
    learning_event = 4'h8;
    pin_chk(1'h1);
    learning_event = 4'h0;
    pin_chk(1'h0);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  // hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    reset_n = 1'h0;
    {long_counter_event, sig_motion_event, tilt_event, step_detect_event} = 4'h0;
    program_event = 8'h00;
    learning_event = 4'h0;
    pin2_embedded_route_enable = 1'h0;
    ack_keep_mask = 8'h00;
    page_select = 4'h0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'h1;
    t_reset_values();
    t_controls();
    t_unlatched();
    t_latched();
    t_pin2();
    give_verdict();
  end
endmodule
